// ### hdl/msoca_top.sv
// overhead channel adaptation: data channel and orderwire insert and extract
//
// Function
// - source puts data channel bytes into D4..D12 of every frame.
// - sink takes D4..D12 out and delivers them as channel data.
// - orderwire source inserts its 64 kbit/s octet stream into E2.
// - orderwire bits are written into the slip store on their own clock.
// - slip store is read at the E2 slot using frame position and slip decision.
// - positive slip skips exactly one octet, once.
// - negative slip sends the previous octet once more.
// - slip store absorbs at least 18 us of wander without errors.
// - orderwire sink extracts the octet carried in E2 each frame.
// - each received octet is latched into a store on the line clock.
// - latched octet is shifted out serially at 64 kHz from a divider.
// - alarm insert gives all-ones at 64 kbit/s within 1 ms.
// - clearing the alarm restores extracted data within 1 ms.
module msoca_top #(
    parameter int SLIP_DEPTH = msoca_pkg::SLIP_DEPTH_DEF,
    parameter int ALARM_CYC = msoca_pkg::ALARM_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic line_timing_clock_i,
    input wire logic line_timing_frame_start_i,
    input wire logic [7:0] src_data_i,
    output logic [7:0] section_access_data_o,
    output logic section_access_valid_o,
    input wire logic [7:0] dcc_tx_data_i,
    output logic data_channel_clock_o,
    input wire logic ow_tx_bit_i,
    input wire logic ow_tx_clock_i,
    input wire logic ow_tx_frame_i,
    output logic ow_slip_pos_o,
    output logic ow_slip_neg_o,
    input wire logic rx_byte_clock_i,
    input wire logic rx_frame_start_i,
    input wire logic [7:0] rx_section_data_i,
    input wire logic trail_fail_in_i,
    output logic [7:0] dcc_rx_data_o,
    output logic dcc_rx_clock_o,
    output logic dcc_server_fail_out_o,
    output logic ow_rx_bit_o,
    output logic ow_rx_clock_o,
    output logic ow_rx_frame_o,
    output logic ow_server_fail_out_o,
    output logic alarm_insert_action_o
);
    localparam int PW = $clog2(SLIP_DEPTH);
    localparam int FW = $clog2(SLIP_DEPTH + 1);
    localparam logic [FW-1:0] FILL_FULL = FW'(SLIP_DEPTH);
    localparam logic [FW-1:0] FILL_HIGH = FW'(SLIP_DEPTH - 1);

    initial begin
        if (SLIP_DEPTH < 4 || SLIP_DEPTH < msoca_pkg::MIN_SLIP_OCTETS)
            $error("SLIP_DEPTH too small");
        if ((SLIP_DEPTH & (SLIP_DEPTH - 1)) != 0) $error("SLIP_DEPTH not a power of two");
    end

    // frame position of the byte now on the bus, for transmit and receive timing
    logic [8:0] tcol_q, tcol_d, rcol_q, rcol_d, tcur_col, rcur_col;
    logic [3:0] trow_q, trow_d, rrow_q, rrow_d, tcur_row, rcur_row;
    logic t_d_slot, t_e2_slot, r_d_slot, r_e2_slot;

    always_comb begin
        tcur_col = line_timing_frame_start_i ? 9'h000 : tcol_q;
        tcur_row = line_timing_frame_start_i ? 4'h0 : trow_q;
        rcur_col = rx_frame_start_i ? 9'h000 : rcol_q;
        rcur_row = rx_frame_start_i ? 4'h0 : rrow_q;
        t_d_slot = tcur_row >= msoca_pkg::D_ROW_FIRST && tcur_row <= msoca_pkg::D_ROW_LAST &&
            (tcur_col == msoca_pkg::D_COL_A || tcur_col == msoca_pkg::D_COL_B ||
             tcur_col == msoca_pkg::D_COL_C);
        r_d_slot = rcur_row >= msoca_pkg::D_ROW_FIRST && rcur_row <= msoca_pkg::D_ROW_LAST &&
            (rcur_col == msoca_pkg::D_COL_A || rcur_col == msoca_pkg::D_COL_B ||
             rcur_col == msoca_pkg::D_COL_C);
        t_e2_slot = tcur_row == msoca_pkg::E2_ROW && tcur_col == msoca_pkg::E2_COL;
        r_e2_slot = rcur_row == msoca_pkg::E2_ROW && rcur_col == msoca_pkg::E2_COL;
        tcol_d = tcol_q;
        trow_d = trow_q;
        rcol_d = rcol_q;
        rrow_d = rrow_q;
        if (line_timing_clock_i) begin
            tcol_d = (tcur_col == msoca_pkg::COL_LAST) ? 9'h000 : tcur_col + 9'h001;
            if (tcur_col == msoca_pkg::COL_LAST)
                trow_d = (tcur_row == msoca_pkg::ROW_LAST) ? 4'h0 : tcur_row + 4'h1;
            else
                trow_d = tcur_row;
        end
        if (rx_byte_clock_i) begin
            rcol_d = (rcur_col == msoca_pkg::COL_LAST) ? 9'h000 : rcur_col + 9'h001;
            if (rcur_col == msoca_pkg::COL_LAST)
                rrow_d = (rcur_row == msoca_pkg::ROW_LAST) ? 4'h0 : rcur_row + 4'h1;
            else
                rrow_d = rcur_row;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tcol_q <= 9'h000;
            trow_q <= 4'h0;
            rcol_q <= 9'h000;
            rrow_q <= 4'h0;
        end else begin
            tcol_q <= tcol_d;
            trow_q <= trow_d;
            rcol_q <= rcol_d;
            rrow_q <= rrow_d;
        end
    end

    // orderwire slip store: octets in flops, one write and one read side
    logic [7:0] mem_q [SLIP_DEPTH];
    logic [7:0] mem_d [SLIP_DEPTH];
    logic [7:0] sr_q, sr_d, last_q, last_d, ow_byte;
    logic [2:0] bc_q, bc_d;
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [FW-1:0] fill_q, fill_d, fill_w;
    logic wr_en, rd_now, slip_pos, slip_neg;

    always_comb begin
        mem_d = mem_q;
        sr_d = sr_q;
        bc_d = bc_q;
        wr_en = 1'b0;
        if (ow_tx_clock_i) begin
            sr_d = {sr_q[6:0], ow_tx_bit_i};
            bc_d = ow_tx_frame_i ? 3'h1 : bc_q + 3'h1;
            // a full store drops the octet; the slip decision keeps that rare
            wr_en = !ow_tx_frame_i && bc_q == 3'h7 && fill_q != FILL_FULL;
        end
        if (wr_en) mem_d[wp_q] = sr_d;
        wp_d = wr_en ? wp_q + PW'(1) : wp_q;
        fill_w = wr_en ? fill_q + FW'(1) : fill_q;
        rd_now = line_timing_clock_i && t_e2_slot;
        slip_neg = rd_now && fill_q == {FW{1'b0}};
        slip_pos = rd_now && fill_q >= FILL_HIGH;
        ow_byte = last_q;
        rp_d = rp_q;
        fill_d = fill_w;
        if (slip_pos) begin
            ow_byte = mem_q[rp_q + PW'(1)];
            rp_d = rp_q + PW'(2);
            fill_d = fill_w - FW'(2);
        end else if (rd_now && !slip_neg) begin
            ow_byte = mem_q[rp_q];
            rp_d = rp_q + PW'(1);
            fill_d = fill_w - FW'(1);
        end
        last_d = rd_now ? ow_byte : last_q;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < SLIP_DEPTH; i++) mem_q[i] <= msoca_pkg::ALL_ONES;
            sr_q <= msoca_pkg::ALL_ONES;
            last_q <= msoca_pkg::ALL_ONES;
            bc_q <= 3'h0;
            wp_q <= '0;
            rp_q <= '0;
            fill_q <= '0;
        end else begin
            mem_q <= mem_d;
            sr_q <= sr_d;
            last_q <= last_d;
            bc_q <= bc_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            fill_q <= fill_d;
        end
    end

    // transmit overhead insertion and receive extraction, all outputs registered
    logic [7:0] out_q, out_d, drx_q, drx_d;
    logic val_q, val_d, dck_q, dck_d, pos_q, pos_d, neg_q, neg_d, rck_q, rck_d;
    logic fail_q, fail_d, e2_we;

    always_comb begin
        out_d = out_q;
        if (line_timing_clock_i) begin
            if (t_d_slot) out_d = dcc_tx_data_i;
            else if (t_e2_slot) out_d = ow_byte;
            else out_d = src_data_i;
        end
        val_d = line_timing_clock_i;
        dck_d = line_timing_clock_i && t_d_slot;
        pos_d = slip_pos;
        neg_d = slip_neg;
        drx_d = (rx_byte_clock_i && r_d_slot) ? rx_section_data_i : drx_q;
        rck_d = rx_byte_clock_i && r_d_slot;
        e2_we = rx_byte_clock_i && r_e2_slot;
        fail_d = trail_fail_in_i;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_q <= 8'h00;
            drx_q <= 8'h00;
            val_q <= 1'b0;
            dck_q <= 1'b0;
            pos_q <= 1'b0;
            neg_q <= 1'b0;
            rck_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            out_q <= out_d;
            drx_q <= drx_d;
            val_q <= val_d;
            dck_q <= dck_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            rck_q <= rck_d;
            fail_q <= fail_d;
        end
    end

    assign section_access_data_o = out_q;
    assign section_access_valid_o = val_q;
    assign data_channel_clock_o = dck_q;
    assign ow_slip_pos_o = pos_q;
    assign ow_slip_neg_o = neg_q;
    assign dcc_rx_data_o = drx_q;
    assign dcc_rx_clock_o = rck_q;
    assign dcc_server_fail_out_o = fail_q;
    assign ow_server_fail_out_o = fail_q;
    assign alarm_insert_action_o = fail_q;

    // serialiser sees the registered alarm so its response follows the output flag
    msoca_ow_sink #(
        .BIT_CYC(msoca_pkg::OW_BIT_CYC),
        .ALARM_CYC(ALARM_CYC)
    ) u_ow_sink (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .octet_i(rx_section_data_i),
        .octet_we_i(e2_we),
        .alarm_i(fail_q),
        .bit_o(ow_rx_bit_o),
        .bit_clk_o(ow_rx_clock_o),
        .frame_o(ow_rx_frame_o)
    );

    a_dcc_tx_insert: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        line_timing_clock_i && t_d_slot |=> section_access_data_o == $past(dcc_tx_data_i)
        && data_channel_clock_o)
        else $error("data channel byte not inserted");
    a_dcc_rx_extract: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rx_byte_clock_i && r_d_slot |=> dcc_rx_clock_o && dcc_rx_data_o == $past(rx_section_data_i))
        else $error("data channel byte not extracted");
    a_ow_normal_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rd_now && !slip_pos && !slip_neg |=> section_access_data_o == $past(mem_q[rp_q])
        && rp_q == $past(rp_q) + PW'(1))
        else $error("E2 octet not read from store");
    a_ow_pos_skip: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        slip_pos |=> rp_q == $past(rp_q) + PW'(2) && ow_slip_pos_o)
        else $error("positive slip did not skip one octet");
    a_ow_neg_repeat: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        slip_neg |=> section_access_data_o == $past(last_q) && rp_q == $past(rp_q))
        else $error("negative slip did not repeat octet");
    a_ow_fill_bound: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fill_q <= FILL_FULL)
        else $error("slip store overfilled");
    a_ow_octet_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ow_tx_clock_i && !ow_tx_frame_i && bc_q == 3'h7 && fill_q < FILL_HIGH && !rd_now
        |=> fill_q == $past(fill_q) + FW'(1))
        else $error("orderwire octet not written");
    a_e2_rx_take: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rx_byte_clock_i && !rx_frame_start_i && rrow_q == msoca_pkg::E2_ROW &&
        rcol_q == msoca_pkg::E2_COL |=> u_ow_sink.latch_q == $past(rx_section_data_i))
        else $error("E2 taken at wrong position");
    a_fail_follows: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        trail_fail_in_i [*2] |-> dcc_server_fail_out_o && ow_server_fail_out_o
        && alarm_insert_action_o)
        else $error("server fail not raised on trail fail");
endmodule

// ### common/msoca_pkg.sv
// shared constants for the multiplex section overhead channel adaptation
package msoca_pkg;
    // frame geometry, counted in bytes of one STM-1 frame
    localparam logic [8:0] COL_LAST = 9'h10D;
    localparam logic [3:0] ROW_LAST = 4'h8;
    // data channel bytes D4..D12: rows 6..8, columns 1, 4 and 7
    localparam logic [3:0] D_ROW_FIRST = 4'h5;
    localparam logic [3:0] D_ROW_LAST = 4'h7;
    localparam logic [8:0] D_COL_A = 9'h000;
    localparam logic [8:0] D_COL_B = 9'h003;
    localparam logic [8:0] D_COL_C = 9'h006;
    // orderwire byte E2: row 9, column 7
    localparam logic [3:0] E2_ROW = 4'h8;
    localparam logic [8:0] E2_COL = 9'h006;
    // clock and channel rates
    localparam int CLK_HZ = 200_000_000;
    localparam int OW_BIT_HZ = 64_000;
    localparam int OW_BIT_CYC = CLK_HZ / OW_BIT_HZ;
    // alarm insertion and removal deadline
    localparam int ALARM_TIME_US = 1000;
    localparam int ALARM_CYC = ALARM_TIME_US * (CLK_HZ / 1_000_000);
    // slip store sizing: wander plus the octet being read
    localparam int WANDER_NS = 18_000;
    localparam int OCTET_NS = 8 * (1_000_000_000 / OW_BIT_HZ);
    localparam int MIN_SLIP_OCTETS = 1 + (WANDER_NS + OCTET_NS - 1) / OCTET_NS;
    localparam int SLIP_DEPTH_DEF = 4;
    // values after reset
    localparam logic [7:0] ALL_ONES = 8'hFF;
endpackage

// ### hdl/msoca_ow_sink.sv
// orderwire sink: octet latch and 64 kbit/s smoothing serialiser with all-ones insertion
module msoca_ow_sink #(
    parameter int BIT_CYC = msoca_pkg::OW_BIT_CYC,
    parameter int ALARM_CYC = msoca_pkg::ALARM_CYC
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] octet_i,
    input wire logic octet_we_i,
    input wire logic alarm_i,
    output logic bit_o,
    output logic bit_clk_o,
    output logic frame_o
);
    localparam logic [11:0] DIV_LAST = 12'(BIT_CYC - 1);

    initial begin
        if (BIT_CYC < 9 || BIT_CYC > 4095) $error("BIT_CYC out of range");
        if (ALARM_CYC < 8 * BIT_CYC) $error("ALARM_CYC shorter than one octet");
    end

    logic [7:0] latch_q, latch_d, shift_q, shift_d;
    logic [11:0] div_q, div_d;
    logic [2:0] cnt_q, cnt_d;
    logic bit_q, bit_d, clk_q, clk_d, frm_q, frm_d;

    // the divider ticks the bit clock; octets are taken from the latch at octet edges
    always_comb begin
        latch_d = octet_we_i ? octet_i : latch_q;
        div_d = (div_q == DIV_LAST) ? 12'h000 : div_q + 12'h001;
        shift_d = shift_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        clk_d = 1'b0;
        frm_d = 1'b0;
        if (div_q == DIV_LAST) begin
            clk_d = 1'b1;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h0) begin
                // a whole octet is loaded here; the alarm is ORed in bit by bit, so data resumes at the next bit clock
                shift_d = {latch_q[6:0], 1'b0};
                bit_d = alarm_i | latch_q[7];
                frm_d = 1'b1;
            end else begin
                shift_d = {shift_q[6:0], 1'b0};
                bit_d = alarm_i | shift_q[7];
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latch_q <= msoca_pkg::ALL_ONES;
            shift_q <= msoca_pkg::ALL_ONES;
            div_q <= 12'h000;
            cnt_q <= 3'h0;
            bit_q <= 1'b1;
            clk_q <= 1'b0;
            frm_q <= 1'b0;
        end else begin
            latch_q <= latch_d;
            shift_q <= shift_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            clk_q <= clk_d;
            frm_q <= frm_d;
        end
    end

    assign bit_o = bit_q;
    assign bit_clk_o = clk_q;
    assign frame_o = frm_q;

    // helper: cycles since the last bit clock, for the rate check
    logic [11:0] gap_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) gap_q <= 12'h000;
        else gap_q <= clk_q ? 12'h001 : gap_q + 12'h001;
    end

    // every pulse, the first after reset too, lands exactly one bit period after the last
    a_bit_rate_exact: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        clk_q |-> gap_q == 12'(BIT_CYC))
        else $error("orderwire bit clock period wrong");
    a_alarm_ones_out: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $past(alarm_i) && clk_q |-> bit_q)
        else $error("all-ones not sent under alarm");
    a_latch_takes_octet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        octet_we_i |=> latch_q == $past(octet_i))
        else $error("received octet not latched");
    a_resume_data_msb: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !alarm_i && div_q == DIV_LAST && cnt_q == 3'h0 |=> bit_q == $past(latch_q[7]))
        else $error("data not resumed after alarm");
endmodule

// ### sim/msoca_far_end.sv
// far-side model: framer byte strobes, data channel client and orderwire client
module msoca_far_end (
    input wire logic clk_i,
    input wire logic reset_n_i,
    output logic line_clock_o,
    output logic line_fs_o,
    output logic rx_fs_o,
    output logic [7:0] src_data_o,
    output logic [7:0] dcc_data_o,
    output logic ow_bit_o,
    output logic ow_clock_o,
    output logic ow_frame_o,
    output logic [11:0] pos_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic phase_q;
    logic wrap;

    // bytes follow the slot position; between strobes they are inverted, not held
    assign src_data_o = phase_q ? pos_o[7:0] : ~pos_o[7:0];
    assign dcc_data_o = phase_q ? ~pos_o[7:0] : pos_o[7:0];
    assign wrap = (pos_o == 12'h97D) || (pos_o == 12'hFFF);

    // one byte strobe every second cycle, frame start on byte 0 of 9 x 270;
    // the receive frame start trails one cycle to meet the looped-back strobe
    always @(negedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q <= 1'b0;
            line_clock_o <= 1'b0;
            line_fs_o <= 1'b0;
            rx_fs_o <= 1'b0;
            pos_o <= 12'hFFF;
        end else begin
            phase_q <= ~phase_q;
            line_clock_o <= ~phase_q;
            line_fs_o <= ~phase_q & wrap;
            rx_fs_o <= line_fs_o;
            if (!phase_q) begin
                pos_o <= wrap ? 12'h000 : pos_o + 12'h001;
            end
        end
    end

    // orderwire line idles low until the first octet is sent
    initial begin
        ow_bit_o = 1'b0;
        ow_clock_o = 1'b0;
        ow_frame_o = 1'b0;
    end

    // one octet, msb first, a strobe every second cycle; bit line inverted between strobes
    task automatic send_octet(input logic [7:0] value);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk_i);
            ow_clock_o <= 1'b1;
            ow_frame_o <= (i == 7);
            ow_bit_o <= value[i];
            @(negedge clk_i);
            ow_clock_o <= 1'b0;
            ow_frame_o <= 1'b0;
            ow_bit_o <= ~value[i];
        end
    endtask
endmodule

// ### sim/msoca_top_tb_top.sv
// self-checking bench for the overhead channel adaptation block
module msoca_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CYC = 3125;
    logic clk_i = 1'b0;
    logic reset_n_i, trail_fail_in_i, line_timing_clock_i, line_timing_frame_start_i;
    logic rx_frame_start_i, ow_tx_bit_i, ow_tx_clock_i, ow_tx_frame_i;
    logic [7:0] src_data_i, dcc_tx_data_i, section_access_data_o, dcc_rx_data_o;
    logic [11:0] pos;
    logic section_access_valid_o, data_channel_clock_o, ow_slip_pos_o, ow_slip_neg_o;
    logic dcc_rx_clock_o, dcc_server_fail_out_o, ow_rx_bit_o, ow_rx_clock_o, ow_rx_frame_o;
    logic ow_server_fail_out_o, alarm_insert_action_o;
    int miscompares = 0;
    int check_count = 0;

    always #2.5 clk_i = ~clk_i;

    // receive side is fed from the transmit side so inserted bytes come back
    msoca_top #(.SLIP_DEPTH(4), .ALARM_CYC(25000)) uut (
        .clk_i, .reset_n_i, .line_timing_clock_i, .line_timing_frame_start_i, .src_data_i,
        .section_access_data_o, .section_access_valid_o, .dcc_tx_data_i, .data_channel_clock_o,
        .ow_tx_bit_i, .ow_tx_clock_i, .ow_tx_frame_i, .ow_slip_pos_o, .ow_slip_neg_o,
        .rx_byte_clock_i(section_access_valid_o), .rx_frame_start_i,
        .rx_section_data_i(section_access_data_o), .trail_fail_in_i, .dcc_rx_data_o,
        .dcc_rx_clock_o, .dcc_server_fail_out_o, .ow_rx_bit_o, .ow_rx_clock_o, .ow_rx_frame_o,
        .ow_server_fail_out_o, .alarm_insert_action_o
    );

    msoca_far_end far (
        .clk_i, .reset_n_i, .line_clock_o(line_timing_clock_i),
        .line_fs_o(line_timing_frame_start_i), .rx_fs_o(rx_frame_start_i),
        .src_data_o(src_data_i), .dcc_data_o(dcc_tx_data_i), .ow_bit_o(ow_tx_bit_i),
        .ow_clock_o(ow_tx_clock_i), .ow_frame_o(ow_tx_frame_i), .pos_o(pos)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        check_count++;
        if (seen !== expected) begin
            miscompares++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, expected);
        end
    endtask

    task automatic final_report();
        if (miscompares == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one whole frame: D slots carry client bytes, others except E2 pass through, D bytes loop back
    task automatic frame_check();
        int n = 0, nb = 0, ntx = 0, nrx = 0;
        logic d;
        logic [7:0] exp_b, last_d;
        while (n < 6000 && !(section_access_valid_o === 1'b1 && pos == 12'h000)) begin
            @(negedge clk_i);
            n++;
        end
        while (nb < 2430 && n < 12000) begin
            if (dcc_rx_clock_o === 1'b1) begin
                check(16'(dcc_rx_data_o), 16'(last_d));
                nrx++;
            end
            if (section_access_valid_o === 1'b1) begin
                d = (pos / 270 >= 5) && (pos / 270 <= 7) && (pos % 270 % 3 == 0)
                    && (pos % 270 <= 6);
                exp_b = d ? ~pos[7:0] : pos[7:0];
                check(16'(data_channel_clock_o), 16'(d));
                if (d) begin
                    ntx++;
                    last_d = exp_b;
                end
                if (pos != 12'h876) begin
                    check(16'(section_access_data_o), 16'(exp_b));
                end
                nb++;
            end
            @(negedge clk_i);
            n++;
        end
        check(16'(ntx * 16 + nrx), 16'h0099);
    endtask

    // next E2 byte on the line, with any slip flag seen at it or one cycle later
    task automatic e2_next(output logic [9:0] got);
        int n = 0;
        while (n < 5000 && !(section_access_valid_o === 1'b1 && pos == 12'h876)) begin
            @(negedge clk_i);
            n++;
        end
        got = {section_access_data_o, ow_slip_pos_o, ow_slip_neg_o};
        @(negedge clk_i);
        got[1:0] = got[1:0] | {ow_slip_pos_o, ow_slip_neg_o};
        check(16'(n < 5000), 16'h0001);
    endtask

    // empty store repeats, a near-full store skips one octet, then drains in order
    task automatic orderwire_slip();
        logic [9:0] g;
        e2_next(g);
        check(16'(g), 16'({8'hFF, 2'b01}));
        far.send_octet(8'h11);
        far.send_octet(8'h22);
        far.send_octet(8'h33);
        e2_next(g);
        check(16'(g), 16'({8'h22, 2'b10}));
        e2_next(g);
        check(16'(g), 16'({8'h33, 2'b00}));
        e2_next(g);
        check(16'(g), 16'({8'h33, 2'b01}));
    endtask

    // collects one serial octet from the next frame pulse, checking the bit spacing
    task automatic rx_octet(output logic [7:0] v);
        int n = 0;
        int gap;
        // at least one edge passes, so a frame pulse launched under the old alarm is skipped
        do begin
            @(negedge clk_i);
            n++;
        end while (n < 25001 && ow_rx_frame_o !== 1'b1);
        check(16'(n < 25001), 16'h0001);
        v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            gap = 0;
            if (i > 0) begin
                do begin
                    @(negedge clk_i);
                    gap++;
                end while (ow_rx_clock_o !== 1'b1 && gap < 4000);
                check(16'(gap), 16'(BIT_CYC));
            end
            v = {v[6:0], ow_rx_bit_o};
        end
    endtask

    // trail fail forces ones and raises fail flags; clearing restores the E2 octet
    task automatic alarm_and_resume();
        int n;
        logic [7:0] v;
        trail_fail_in_i = 1'b1;
        @(negedge clk_i);
        check(16'({dcc_server_fail_out_o, ow_server_fail_out_o, alarm_insert_action_o}),
              16'h0007);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(negedge clk_i);
                n++;
            end while (ow_rx_clock_o !== 1'b1 && n < 3200);
            check(16'({n < 3200, ow_rx_bit_o}), 16'h0003);
        end
        trail_fail_in_i = 1'b0;
        @(negedge clk_i);
        check(16'({dcc_server_fail_out_o, ow_server_fail_out_o, alarm_insert_action_o}),
              16'h0000);
        rx_octet(v);
        check(16'(v), 16'h0033);
    endtask

    // main sequence; inputs change on the falling edge only
    initial begin
        reset_n_i = 1'b0;
        trail_fail_in_i = 1'b0;
        repeat (12) @(negedge clk_i);
        reset_n_i <= 1'b1;
        frame_check();
        orderwire_slip();
        alarm_and_resume();
        final_report();
    end

    // the sequence needs about 75000 cycles at worst; a hang is cut off beyond that
    initial begin
        repeat (95000) @(posedge clk_i);
        miscompares++;
        final_report();
    end
endmodule
